// File: logic/pci_target_host_port.sv
// target side of the host bus port with mode detection and strobe latch
`timescale 1ns/10ps
module pci_target_host_port (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  input wire logic clk_pin_in,
  input wire logic [31:0] ad_in,
  output logic [31:0] ad_out,
  output logic ad_oe_out,
  input wire logic [3:0] cbe_n_in,
  input wire logic par_in,
  output logic par_out,
  output logic par_oe_out,
  input wire logic frame_n_in,
  input wire logic irdy_n_in,
  input wire logic idsel_in,
  output logic trdy_n_out,
  output logic stop_n_out,
  output logic devsel_n_out,
  output logic ctl_oe_out,
  output logic perr_n_out,
  output logic perr_oe_out,
  output logic int_n_out,
  output logic int_oe_out,
  input wire logic ale_in,
  output logic [7:0] mp_addr_out,
  input wire logic [31:0] bar_base_in,
  input wire logic irq_req_in,
  input wire logic ack_in,
  input wire logic [31:0] rdata_in,
  output logic req_out,
  output logic req_write_out,
  output logic [31:0] req_addr_out,
  output logic [3:0] req_cmd_out,
  output logic [3:0] req_be_out,
  output logic [31:0] req_wdata_out,
  output host_port_pkg::host_mode_t mode_out,
  output logic mode_locked_out
);
  typedef struct packed {
    host_port_pkg::tgt_state_t st;
    logic [1:0] frame_s;
    logic [1:0] irdy_s;
    logic [1:0] idsel_s;
    logic [1:0] ale_s;
    logic [1:0] par_s;
    logic [1:0] clkp_s;
    logic [31:0] ad_m;
    logic [31:0] ad_s;
    logic [3:0] cbe_m;
    logic [3:0] cbe_s;
    logic frame_prev;
    logic [31:0] addr;
    logic [3:0] cmd;
    logic [3:0] be;
    logic [31:0] wdata;
    logic chk;
    logic exp_par;
    logic req;
    logic trdy_n;
    logic stop_n;
    logic devsel_n;
    logic ctl_oe;
    logic [31:0] ad_out;
    logic ad_oe;
    logic par_out;
    logic par_oe;
    logic perr_n;
    logic perr_oe;
    logic int_n;
    logic int_oe;
    logic [7:0] mp_addr;
  } port_t;

  port_t q;
  port_t n;
  host_port_pkg::host_mode_t mode;
  logic locked;

  mode_detect u_mode_detect (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .ce_in(ce_in),
    .pin_in(q.clkp_s[1]),
    .mode_out(mode),
    .locked_out(locked)
  );

  always_comb begin
    n = q;
    n.req = 1'b0;
    n.chk = 1'b0;
    // two stages on every pin; only stage two is looked at
    n.frame_s = {q.frame_s[0], frame_n_in}; // RULE_02
    n.irdy_s = {q.irdy_s[0], irdy_n_in}; // RULE_02
    n.idsel_s = {q.idsel_s[0], idsel_in}; // RULE_02
    n.ale_s = {q.ale_s[0], ale_in};
    n.par_s = {q.par_s[0], par_in}; // RULE_02
    n.clkp_s = {q.clkp_s[0], clk_pin_in};
    n.ad_m = ad_in;
    n.ad_s = q.ad_m;
    n.cbe_m = cbe_n_in;
    n.cbe_s = q.cbe_m;
    n.frame_prev = q.frame_s[1];
    // level request while pending; the pin itself only ever pulls low
    n.int_oe = irq_req_in; // RULE_15
    // parity trails the data it covers by one cycle
    n.par_out = host_port_pkg::even_par(q.ad_out, q.be); // RULE_06
    n.par_oe = q.ad_oe;
    if (!q.perr_n) begin
      n.perr_n = 1'b1;
    end else if (q.perr_oe) begin
      n.perr_oe = 1'b0;
    end
    if (q.chk && (q.par_s[1] != q.exp_par)) begin
      n.perr_n = 1'b0; // RULE_13
      n.perr_oe = 1'b1; // RULE_13
    end
    // transparent while the latch enable is high, holds once it drops
    if ((mode == host_port_pkg::MODE_STROBE) && q.ale_s[1]) begin
      n.mp_addr = q.ad_s[7:0]; // RULE_16 RULE_17
    end
    // drive controls high for one cycle before letting go
    if (q.st == host_port_pkg::ST_IDLE) begin
      n.ctl_oe = 1'b0;
    end
    unique case (q.st)
      host_port_pkg::ST_IDLE: begin
        if ((mode == host_port_pkg::MODE_PCI) && q.frame_prev &&
            !q.frame_s[1]) begin // RULE_07
          // a miss must leave the user side untouched
          if (host_port_pkg::is_hit(q.ad_s, q.cbe_s, q.idsel_s[1],
                                    bar_base_in)) begin // RULE_12
            n.addr = q.ad_s; // RULE_04
            n.cmd = q.cbe_s; // RULE_05
            n.devsel_n = 1'b0; // RULE_11
            n.ctl_oe = 1'b1;
            n.st = host_port_pkg::ST_WDATA;
          end
        end
      end
      host_port_pkg::ST_WDATA: begin
        if (!q.irdy_s[1]) begin // RULE_09
          n.be = q.cbe_s; // RULE_05
          n.wdata = q.ad_s; // RULE_04
          n.req = 1'b1;
          n.st = host_port_pkg::ST_WAIT;
          if (q.cmd[host_port_pkg::CMD_WRITE_BIT]) begin
            n.chk = 1'b1;
            n.exp_par = host_port_pkg::even_par(q.ad_s, q.cbe_s); // RULE_06
          end
        end
      end
      host_port_pkg::ST_WAIT: begin
        if (ack_in) begin
          n.trdy_n = 1'b0; // RULE_08
          // single data phase per access: disconnect with data
          n.stop_n = 1'b0; // RULE_10
          if (!q.cmd[host_port_pkg::CMD_WRITE_BIT]) begin
            n.ad_out = rdata_in; // RULE_04
            n.ad_oe = 1'b1;
          end
          n.st = host_port_pkg::ST_DATA;
        end
      end
      host_port_pkg::ST_DATA: begin
        n.trdy_n = 1'b1;
        n.ad_oe = 1'b0;
        n.st = host_port_pkg::ST_TURN;
      end
      host_port_pkg::ST_TURN: begin
        if (q.frame_s[1]) begin
          n.stop_n = 1'b1; // RULE_10
          n.devsel_n = 1'b1;
          n.st = host_port_pkg::ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      q <= '0; // RULE_14
      q.st <= host_port_pkg::ST_IDLE;
      q.frame_s <= {2{host_port_pkg::RST_HIGH}};
      q.irdy_s <= {2{host_port_pkg::RST_HIGH}};
      q.frame_prev <= host_port_pkg::RST_HIGH;
      q.trdy_n <= host_port_pkg::RST_HIGH;
      q.stop_n <= host_port_pkg::RST_HIGH;
      q.devsel_n <= host_port_pkg::RST_HIGH;
      q.perr_n <= host_port_pkg::RST_HIGH;
      q.int_n <= host_port_pkg::RST_LOW;
    end else if (ce_in) begin
      q <= n;
    end
  end

  assign ad_out = q.ad_out;
  assign ad_oe_out = q.ad_oe;
  assign par_out = q.par_out;
  assign par_oe_out = q.par_oe;
  assign trdy_n_out = q.trdy_n;
  assign stop_n_out = q.stop_n;
  assign devsel_n_out = q.devsel_n;
  assign ctl_oe_out = q.ctl_oe;
  assign perr_n_out = q.perr_n;
  assign perr_oe_out = q.perr_oe;
  assign int_n_out = q.int_n;
  assign int_oe_out = q.int_oe;
  assign mp_addr_out = q.mp_addr;
  assign req_out = q.req;
  assign req_write_out = q.cmd[host_port_pkg::CMD_WRITE_BIT];
  assign req_addr_out = q.addr;
  assign req_cmd_out = q.cmd;
  assign req_be_out = q.be;
  assign req_wdata_out = q.wdata;
  assign mode_out = mode;
  assign mode_locked_out = locked;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);

  a_trdy_after_ack: assert property ( // RULE_08
    $fell(trdy_n_out) |-> $past(ack_in) && !devsel_n_out)
    else $error("target ready without user answer");
  a_stop_with_trdy: assert property ( // RULE_10
    !trdy_n_out |-> !stop_n_out ##1 !stop_n_out)
    else $error("stop not held with target ready");
  a_claim_only_pci: assert property ( // RULE_11
    $fell(devsel_n_out) |-> mode == host_port_pkg::MODE_PCI && ctl_oe_out)
    else $error("device select outside bus mode");
  a_cfg_needs_idsel: assert property ( // RULE_12
    $fell(devsel_n_out) && host_port_pkg::is_cfg(req_cmd_out)
      |-> $past(q.idsel_s[1]))
    else $error("config claim without config select");
  a_mode_stays: assert property ( // RULE_18
    locked |=> locked && $stable(mode))
    else $error("mode changed after lock");
  a_par_even: assert property ( // RULE_06
    $rose(par_oe_out) |-> $past(ad_oe_out) &&
      (par_out == host_port_pkg::even_par($past(ad_out), $past(q.be))))
    else $error("read parity not even");
  a_perr_pulse: assert property ( // RULE_13
    $fell(perr_n_out) |-> perr_oe_out && $past(q.chk)
      ##1 perr_n_out && perr_oe_out)
    else $error("parity error pulse malformed");
  a_int_level: assert property ( // RULE_15
    ce_in && irq_req_in |=> int_oe_out && !int_n_out)
    else $error("interrupt not pulled low");
  a_strobe_latch: assert property ( // RULE_17
    ce_in && mode == host_port_pkg::MODE_STROBE && q.ale_s[1]
      |=> mp_addr_out == $past(q.ad_s[7:0]))
    else $error("strobe address not latched");

  c_read_done: cover property (
    !trdy_n_out && ad_oe_out ##1 par_oe_out);
  c_write_done: cover property (!trdy_n_out && req_write_out);
  c_parity_err: cover property ($fell(perr_n_out));
  c_strobe_mode: cover property (locked && mode == host_port_pkg::MODE_STROBE);
endmodule : pci_target_host_port

// File: logic/host_port_pkg.sv
// constants, types and helpers shared by the host bus port
// Overview of operation
// RULE_01: clock pin toggling, high or low picks mode
// RULE_02: bus inputs sampled on rising clock edge
// RULE_03: host keeps clock stable 100 us before reset
// RULE_04: address phase 32 bits, data bytes little-endian
// RULE_05: master drives command then byte enables
// RULE_06: parity is even over data and command
// RULE_07: master asserts frame to start transaction
// RULE_08: target ready only when phase can complete
// RULE_09: master asserts initiator ready when able
// RULE_10: stop asserted to end the transaction
// RULE_11: device select asserted after own decode
// RULE_12: config select acts as chip select
// RULE_13: data parity errors drive parity error output
// RULE_14: reset accepted asynchronously at any time
// RULE_15: interrupt is level, active low, open drain
// RULE_16: strobe mode carries 8-bit address then data
// RULE_17: strobe mode latches address with latch enable
// RULE_18: mode settles after reset and stays fixed
package host_port_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int DETECT_WINDOW_NS = 1000;
  localparam int DETECT_CYCLES =
    (DETECT_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] DETECT_CNT_LAST = 8'(DETECT_CYCLES - 1);
  localparam logic [2:0] TOGGLE_MIN = 3'h2;
  localparam logic [2:0] TOGGLE_SAT = 3'h7;
  localparam logic [3:0] CMD_MEM_RD = 4'h6;
  localparam logic [3:0] CMD_MEM_WR = 4'h7;
  localparam logic [3:0] CMD_CFG_RD = 4'ha;
  localparam logic [3:0] CMD_CFG_WR = 4'hb;
  localparam logic [1:0] CFG_TYPE0 = 2'h0;
  localparam int BAR_LSB = 12;
  localparam int CMD_WRITE_BIT = 0;
  localparam logic RST_LOW = 1'b0;
  localparam logic RST_HIGH = 1'b1;

  typedef enum logic [1:0] {
    MODE_NONE = 2'h0,
    MODE_PCI = 2'h1,
    MODE_STROBE = 2'h2,
    MODE_DSTROBE = 2'h3
  } host_mode_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_WDATA = 5'h02,
    ST_WAIT = 5'h04,
    ST_DATA = 5'h08,
    ST_TURN = 5'h10
  } tgt_state_t;

  function automatic logic even_par(input logic [31:0] ad,
                                    input logic [3:0] cbe);
    return ^{ad, cbe};
  endfunction : even_par

  function automatic logic is_cfg(input logic [3:0] cmd);
    return (cmd == CMD_CFG_RD) || (cmd == CMD_CFG_WR);
  endfunction : is_cfg

  function automatic logic is_hit(input logic [31:0] ad,
                                  input logic [3:0] cmd,
                                  input logic idsel,
                                  input logic [31:0] bar);
    if (is_cfg(cmd)) begin
      return idsel && (ad[1:0] == CFG_TYPE0);
    end
    if ((cmd == CMD_MEM_RD) || (cmd == CMD_MEM_WR)) begin
      return ad[31:BAR_LSB] == bar[31:BAR_LSB];
    end
    return 1'b0;
  endfunction : is_hit
endpackage : host_port_pkg

// File: logic/mode_detect.sv
// watches the synchronised clock pin after reset and fixes the host mode
`timescale 1ns/10ps
module mode_detect (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  input wire logic pin_in,
  output host_port_pkg::host_mode_t mode_out,
  output logic locked_out
);
  typedef struct packed {
    logic [7:0] cnt;
    logic [2:0] tog;
    logic prev;
    logic primed;
    logic locked;
    host_port_pkg::host_mode_t mode;
  } det_t;

  det_t q;
  det_t n;

  // the pin cannot be judged under reset, so the window opens at release
  always_comb begin
    n = q;
    if (!q.locked) begin
      n.prev = pin_in;
      n.primed = 1'b1;
      if (q.primed && (pin_in != q.prev) &&
          (q.tog != host_port_pkg::TOGGLE_SAT)) begin
        n.tog = q.tog + 3'h1;
      end
      if (q.cnt == host_port_pkg::DETECT_CNT_LAST) begin
        n.locked = 1'b1; // RULE_18
        if (q.tog >= host_port_pkg::TOGGLE_MIN) begin
          n.mode = host_port_pkg::MODE_PCI; // RULE_01
        end else if (pin_in) begin
          n.mode = host_port_pkg::MODE_STROBE; // RULE_01
        end else begin
          n.mode = host_port_pkg::MODE_DSTROBE; // RULE_01
        end
      end else begin
        n.cnt = q.cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      q <= '0; // RULE_14
    end else if (ce_in) begin
      q <= n;
    end
  end

  assign mode_out = q.mode;
  assign locked_out = q.locked;
endmodule : mode_detect

// File: verification/bus_master_model.sv
// behavioural bus master that runs single data phase transfers
`timescale 1ns/10ps
module bus_master_model (
  input wire logic clk_in,
  input wire logic [31:0] ad_out_in,
  input wire logic ad_oe_in,
  input wire logic trdy_n_in,
  output logic [31:0] ad_w_out,
  output logic [3:0] cbe_n_out,
  output logic par_out,
  output logic frame_n_out,
  output logic irdy_n_out
);
  logic [31:0] ad_q = 32'h0;
  logic ad_en = 1'b0;
  // released lines show the inverse so a stale value never passes
  assign ad_w_out = ad_oe_in ? ad_out_in : (ad_en ? ad_q : ~ad_q);
  initial begin
    cbe_n_out = 4'hf;
    par_out = 1'b0;
    frame_n_out = 1'b1;
    irdy_n_out = 1'b1;
  end
  task automatic access(input logic [3:0] cmd, input logic [31:0] addr,
    input logic [3:0] be, input logic [31:0] wd, input logic bad,
    output logic [31:0] rd, output logic ok);
    int n;
    n = 0;
    @(posedge clk_in) #1;
    frame_n_out = 1'b0;
    ad_q = addr;
    ad_en = 1'b1;
    cbe_n_out = cmd;
    par_out = ^{addr, cmd};
    @(posedge clk_in) #1;
    irdy_n_out = 1'b0;
    cbe_n_out = be;
    ad_q = wd;
    ad_en = cmd[0];
    @(posedge clk_in) #1;
    par_out = ^{wd, be} ^ bad;
    // one data phase only: hold until target ready is sampled low or 20 clocks pass
    do begin
      @(posedge clk_in);
      n++;
    end while (trdy_n_in !== 1'b0 && n < 20);
    rd = ad_w_out;
    ok = (n < 20);
    #1;
    frame_n_out = 1'b1;
    irdy_n_out = 1'b1;
    ad_en = 1'b0;
    cbe_n_out = ~be;
    @(posedge clk_in) #1;
    par_out = ~par_out;
  endtask : access
endmodule : bus_master_model

// File: verification/tb_pci_target_host_port.sv
// self-checking bench for the host bus target port
`timescale 1ns/10ps
module tb_pci_target_host_port;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic clk_pin_in = 1'b0;
  logic tog = 1'b0;
  logic idsel_in = 1'b0;
  logic ale_in = 1'b0;
  logic ce_in = 1'b1;
  logic irq_req_in = 1'b0;
  logic ack_in = 1'b0;
  logic trdy_d = 1'b0;
  logic [31:0] rdata_in = 32'h0;
  logic [31:0] ad_w, ad_out, req_addr_out, req_wdata_out, cap_addr, cap_wd;
  logic [3:0] cbe_n, req_cmd_out, req_be_out, cap_cmd, cap_be;
  logic m_par, par_w, frame_n, irdy_n, ad_oe_out, par_out, par_oe_out;
  logic trdy_n_out, stop_n_out, devsel_n_out, ctl_oe_out, perr_n_out;
  logic perr_oe_out, int_n_out, int_oe_out, req_out, req_write_out;
  logic mode_locked_out, t_stop, t_dev, par_cap;
  logic [7:0] mp_addr_out;
  host_port_pkg::host_mode_t mode_out;
  int num_errors = 0;
  int comparisons = 0;
  int perr_cnt = 0;
  int req_cnt = 0;
  assign par_w = par_oe_out ? par_out : m_par;
  pci_target_host_port dut_u (.clk_in, .resetn_in, .ce_in,
    .clk_pin_in, .ad_in(ad_w), .ad_out, .ad_oe_out, .cbe_n_in(cbe_n),
    .par_in(par_w), .par_out, .par_oe_out, .frame_n_in(frame_n),
    .irdy_n_in(irdy_n), .idsel_in, .trdy_n_out, .stop_n_out, .devsel_n_out,
    .ctl_oe_out, .perr_n_out, .perr_oe_out, .int_n_out, .int_oe_out,
    .ale_in, .mp_addr_out, .bar_base_in(32'h4000_0000), .irq_req_in,
    .ack_in, .rdata_in, .req_out, .req_write_out, .req_addr_out,
    .req_cmd_out, .req_be_out, .req_wdata_out, .mode_out, .mode_locked_out);
  bus_master_model master_u (.clk_in, .ad_out_in(ad_out),
    .ad_oe_in(ad_oe_out), .trdy_n_in(trdy_n_out), .ad_w_out(ad_w),
    .cbe_n_out(cbe_n), .par_out(m_par), .frame_n_out(frame_n),
    .irdy_n_out(irdy_n));
  always #5 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    if (tog) clk_pin_in <= #1 ~clk_pin_in;
    ack_in <= #1 req_out;
    trdy_d <= (trdy_n_out === 1'b0);
    if (trdy_n_out === 1'b0) begin
      t_stop <= stop_n_out;
      t_dev <= devsel_n_out;
    end
    if (trdy_d && par_oe_out === 1'b1) par_cap <= par_out;
    if (perr_n_out === 1'b0 && perr_oe_out === 1'b1) perr_cnt++;
    if (req_out === 1'b1) begin
      req_cnt++;
      cap_addr <= req_addr_out;
      cap_wd <= req_wdata_out;
      cap_cmd <= req_cmd_out;
      cap_be <= req_be_out;
    end
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic wrap_up;
    if (num_errors == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up
  task automatic do_reset(input logic tog_v, input logic pin_v);
    @(posedge clk_in) #1;
    resetn_in = 1'b0;
    tog = tog_v;
    clk_pin_in = pin_v;
    #1 cmp(32'({mode_out, ctl_oe_out}), 32'h0);
    repeat (6) @(posedge clk_in);
    #1 resetn_in = 1'b1;
    repeat (105) @(posedge clk_in);
    #1 cmp(32'(mode_locked_out), 32'h1);
  endtask : do_reset
  task automatic run_strobe;
    logic [31:0] rd;
    logic ok;
    do_reset(1'b0, 1'b1);
    cmp(32'(mode_out), 32'(host_port_pkg::MODE_STROBE));
    master_u.access(host_port_pkg::CMD_MEM_RD, 32'h4000_0000, 4'h0, 32'h0,
                    1'b0, rd, ok);
    cmp(32'({ok, req_cnt[0]}), 32'h0);
    master_u.ad_q = 32'h5a;
    master_u.ad_en = 1'b1;
    ale_in = 1'b1;
    repeat (5) @(posedge clk_in);
    #1 cmp(32'(mp_addr_out), 32'h5a);
    ale_in = 1'b0;
    master_u.ad_q = 32'ha5;
    repeat (5) @(posedge clk_in);
    #1 cmp(32'(mp_addr_out), 32'h5a);
    master_u.ad_en = 1'b0;
  endtask : run_strobe
  task automatic run_dstrobe;
    do_reset(1'b0, 1'b0);
    cmp(32'(mode_out), 32'(host_port_pkg::MODE_DSTROBE));
  endtask : run_dstrobe
  task automatic run_rd;
    logic [31:0] rd;
    logic ok;
    do_reset(1'b1, 1'b0);
    cmp(32'(mode_out), 32'(host_port_pkg::MODE_PCI));
    rdata_in = 32'hc3a5_0f96;
    master_u.access(host_port_pkg::CMD_MEM_RD, 32'h4000_0124, 4'h5, 32'h0,
                    1'b0, rd, ok);
    @(posedge clk_in) #1;
    cmp(rd, 32'hc3a5_0f96);
    cmp(32'(par_cap), 32'(^{32'hc3a5_0f96, 4'h5}));
    cmp(32'({t_stop, t_dev}), 32'h0);
    cmp(cap_addr, 32'h4000_0124);
    cmp(32'({cap_cmd, cap_be}), 32'h65);
    repeat (6) @(posedge clk_in);
    #1 cmp(32'(ctl_oe_out), 32'h0);
  endtask : run_rd
  task automatic run_wr;
    logic [31:0] rd;
    logic ok;
    idsel_in = 1'b1;
    master_u.access(host_port_pkg::CMD_CFG_WR, 32'h10, 4'h0, 32'h8e71_2d4b,
                    1'b0, rd, ok);
    repeat (8) @(posedge clk_in);
    cmp(32'(ok), 32'h1);
    cmp(cap_wd, 32'h8e71_2d4b);
    cmp(32'({req_write_out, cap_cmd}), 32'h1b);
    cmp(32'(perr_cnt), 32'h0);
    master_u.access(host_port_pkg::CMD_CFG_WR, 32'h10, 4'h0, 32'h1,
                    1'b1, rd, ok);
    repeat (8) @(posedge clk_in);
    cmp(32'(perr_cnt), 32'h1);
    idsel_in = 1'b0;
    master_u.access(host_port_pkg::CMD_CFG_RD, 32'h10, 4'h0, 32'h0,
                    1'b0, rd, ok);
    cmp(32'({ok, devsel_n_out}), 32'h1);
    repeat (4) @(posedge clk_in);
    master_u.access(host_port_pkg::CMD_MEM_RD, 32'h5000_0000, 4'h0, 32'h0,
                    1'b0, rd, ok);
    cmp(32'({ok, req_cnt[3:0]}), 32'h3);
  endtask : run_wr
  task automatic run_irq;
    @(posedge clk_in) #1;
    ce_in = 1'b0;
    irq_req_in = 1'b1;
    // a frozen port must not pass the request on
    repeat (4) @(posedge clk_in);
    #1 ce_in = 1'b1;
    cmp(32'(int_oe_out), 32'h0);
    repeat (8) @(posedge clk_in);
    #1 cmp(32'({int_oe_out, int_n_out}), 32'h2);
    irq_req_in = 1'b0;
    repeat (3) @(posedge clk_in);
    #1 cmp(32'(int_oe_out), 32'h0);
    tog = 1'b0;
    repeat (20) @(posedge clk_in);
    #1 cmp(32'(mode_out), 32'(host_port_pkg::MODE_PCI));
  endtask : run_irq
  initial begin
    run_strobe();
    run_dstrobe();
    run_rd();
    run_wr();
    run_irq();
    wrap_up();
  end
  // the sequence needs well under 1500 cycles; this allows four times it
  initial begin
    #60000;
    num_errors++;
    wrap_up();
  end
endmodule : tb_pci_target_host_port
